//--- rtl/branch_compare_pkg.sv
// Constants and types shared by the compare, skip and branch execution unit.
// Assumes 16-bit instruction words and an 11-bit word-addressed program counter.
package branch_compare_pkg;

   // Program counter width in words
   localparam int PC_W = 11;

   // Status flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // Reset values
   localparam logic [7:0] STATUS_FLAGS_REGISTER_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;

   // Opcode masks and match values
   localparam logic [15:0] MASK_DECREMENT = 16'hFE0F;
   localparam logic [15:0] VAL_DECREMENT = 16'h940A;
   localparam logic [15:0] MASK_LOGIC = 16'hFC00;
   localparam logic [15:0] VAL_AND = 16'h2000;
   localparam logic [15:0] VAL_XOR = 16'h2400;
   localparam logic [15:0] MASK_FILL = 16'hFF0F;
   localparam logic [15:0] VAL_FILL = 16'hEF0F;
   localparam logic [15:0] MASK_REL = 16'hF000;
   localparam logic [15:0] VAL_REL_JUMP = 16'hC000;
   localparam logic [15:0] VAL_REL_CALL = 16'hD000;
   localparam logic [15:0] VAL_IND_JUMP = 16'h9409;
   localparam logic [15:0] VAL_IND_CALL = 16'h9509;
   localparam logic [15:0] MASK_CMP = 16'hFC00;
   localparam logic [15:0] VAL_CMP_SKIP = 16'h1000;
   localparam logic [15:0] VAL_CMP_REGS = 16'h1400;
   localparam logic [15:0] VAL_CMP_CARRY = 16'h0400;
   localparam logic [15:0] MASK_CMP_IMM = 16'hF000;
   localparam logic [15:0] VAL_CMP_IMM = 16'h3000;
   localparam logic [15:0] MASK_SKIP_RB = 16'hFE08;
   localparam logic [15:0] VAL_SKIP_RB_CLEAR = 16'hFC00;
   localparam logic [15:0] VAL_SKIP_RB_SET = 16'hFE00;
   localparam logic [15:0] MASK_SKIP_IO = 16'hFF00;
   localparam logic [15:0] VAL_SKIP_IO_CLEAR = 16'h9900;
   localparam logic [15:0] VAL_SKIP_IO_SET = 16'h9B00;
   localparam logic [15:0] MASK_BRANCH = 16'hFC00;
   localparam logic [15:0] VAL_BR_SET = 16'hF000;
   localparam logic [15:0] VAL_BR_CLEAR = 16'hF400;
   // Two-word instructions, seen when sizing a skip
   localparam logic [15:0] MASK_LONG_MEM = 16'hFC0F;
   localparam logic [15:0] VAL_LONG_MEM = 16'h9000;
   localparam logic [15:0] MASK_LONG_FLOW = 16'hFE0C;
   localparam logic [15:0] VAL_LONG_FLOW = 16'h940C;

   // Constant operands
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] SIGNED_MIN = 8'h80;

   // Cycle counts
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   // Instruction classes handled here
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_DECREMENT = 5'h01, OP_TEST = 5'h02, OP_ZERO_REG = 5'h03,
      OP_FILL_ONES = 5'h04, OP_REL_JUMP = 5'h05, OP_REL_CALL = 5'h06, OP_IND_JUMP = 5'h07,
      OP_IND_CALL = 5'h08, OP_CMP_SKIP = 5'h09, OP_CMP_REGS = 5'h0A, OP_CMP_CARRY = 5'h0B,
      OP_CMP_IMM = 5'h0C, OP_SKIP_RB_CLEAR = 5'h0D, OP_SKIP_RB_SET = 5'h0E,
      OP_SKIP_IO_CLEAR = 5'h0F, OP_SKIP_IO_SET = 5'h10, OP_BR_SET = 5'h11, OP_BR_CLEAR = 5'h12
   } op_t;

   // Issue state
   typedef enum logic [0:0] {ST_READY = 1'b0, ST_STALL = 1'b1} exec_state_t;

endpackage : branch_compare_pkg

//--- rtl/branch_compare_exec_unit.sv
// Execution unit for decrement, test, clear, fill, jumps, calls, compares,
// skips and status-flag branches of an 8-bit RISC core.
// Assumes the core presents operand values with each instruction word.
//
// Functional notes
// - Decrement writes Rd-1 in one cycle, updating Z N V, carry kept.
// - Test ANDs register with itself, writes it back, sets Z N V, one cycle.
// - Clear XORs register to zero updating Z N V; fill writes FFs, flags kept.
// - Relative jump: PC+k+1 in two cycles; relative call same in three.
// - Indirect jump loads PC from Z pointer in two cycles, call three, no flags.
// - Compare-skip-equal skips next instruction on match, 1/2/3 cycles, no flags.
// - Compares subtract without storing, update Z N V C H, one cycle.
// - Register bit skips test a bit and skip when condition holds, no flags.
// - I/O bit skips test an I/O bit and skip when condition holds, 1 to 3 cycles.
// - Status-bit branches test chosen flag; one cycle not taken, two taken.
// - Equal branches on Z one, not-equal on Z zero, flags unchanged.
// - Carry-set and lower branch on C one; carry-clear and same-higher on zero.
// - Minus branches on N one, plus on N zero, one or two cycles.
// - Signed greater-equal branches when N xor V is zero, less-than when one.
// - Half-carry branches on H set or clear, one or two cycles, no flags.
// - Transfer-bit branches on T set or clear, one or two cycles.
// - Overflow branches on V set or clear without changing flags.
// - Interrupt-enable branches on I one or zero, one or two cycles.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module branch_compare_exec_unit (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Instruction issue
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic [15:0] nextWord,
   // Operand values from register file and I/O bus
   input wire logic [7:0] opD,
   input wire logic [7:0] opR,
   input wire logic [7:0] ioData,
   input wire logic [15:0] zPointer,
   // Issue handshake and state
   output logic ready,
   output logic [branch_compare_pkg::PC_W-1:0] pc,
   output logic [7:0] status_flags_register,
   output logic unknownOp,
   // Register file write
   output logic regWe,
   output logic [4:0] regAddr,
   output logic [7:0] regData,
   // Return address push
   output logic pushValid,
   output logic [branch_compare_pkg::PC_W-1:0] pushAddr
);

   // Classify an instruction word
   function automatic branch_compare_pkg::op_t classify(input logic [15:0] w);
      logic sameRegs;
      sameRegs = (w[8:4] == {w[9], w[3:0]});
      if ((w & branch_compare_pkg::MASK_DECREMENT) == branch_compare_pkg::VAL_DECREMENT)
         classify = branch_compare_pkg::OP_DECREMENT;
      else if (((w & branch_compare_pkg::MASK_LOGIC) == branch_compare_pkg::VAL_AND) && sameRegs)
         classify = branch_compare_pkg::OP_TEST;
      else if (((w & branch_compare_pkg::MASK_LOGIC) == branch_compare_pkg::VAL_XOR) && sameRegs)
         classify = branch_compare_pkg::OP_ZERO_REG;
      else if ((w & branch_compare_pkg::MASK_FILL) == branch_compare_pkg::VAL_FILL)
         classify = branch_compare_pkg::OP_FILL_ONES;
      else if ((w & branch_compare_pkg::MASK_REL) == branch_compare_pkg::VAL_REL_JUMP)
         classify = branch_compare_pkg::OP_REL_JUMP;
      else if ((w & branch_compare_pkg::MASK_REL) == branch_compare_pkg::VAL_REL_CALL)
         classify = branch_compare_pkg::OP_REL_CALL;
      else if (w == branch_compare_pkg::VAL_IND_JUMP)
         classify = branch_compare_pkg::OP_IND_JUMP;
      else if (w == branch_compare_pkg::VAL_IND_CALL)
         classify = branch_compare_pkg::OP_IND_CALL;
      else if ((w & branch_compare_pkg::MASK_CMP) == branch_compare_pkg::VAL_CMP_SKIP)
         classify = branch_compare_pkg::OP_CMP_SKIP;
      else if ((w & branch_compare_pkg::MASK_CMP) == branch_compare_pkg::VAL_CMP_REGS)
         classify = branch_compare_pkg::OP_CMP_REGS;
      else if ((w & branch_compare_pkg::MASK_CMP) == branch_compare_pkg::VAL_CMP_CARRY)
         classify = branch_compare_pkg::OP_CMP_CARRY;
      else if ((w & branch_compare_pkg::MASK_CMP_IMM) == branch_compare_pkg::VAL_CMP_IMM)
         classify = branch_compare_pkg::OP_CMP_IMM;
      else if ((w & branch_compare_pkg::MASK_SKIP_RB) == branch_compare_pkg::VAL_SKIP_RB_CLEAR)
         classify = branch_compare_pkg::OP_SKIP_RB_CLEAR;
      else if ((w & branch_compare_pkg::MASK_SKIP_RB) == branch_compare_pkg::VAL_SKIP_RB_SET)
         classify = branch_compare_pkg::OP_SKIP_RB_SET;
      else if ((w & branch_compare_pkg::MASK_SKIP_IO) == branch_compare_pkg::VAL_SKIP_IO_CLEAR)
         classify = branch_compare_pkg::OP_SKIP_IO_CLEAR;
      else if ((w & branch_compare_pkg::MASK_SKIP_IO) == branch_compare_pkg::VAL_SKIP_IO_SET)
         classify = branch_compare_pkg::OP_SKIP_IO_SET;
      else if ((w & branch_compare_pkg::MASK_BRANCH) == branch_compare_pkg::VAL_BR_SET)
         classify = branch_compare_pkg::OP_BR_SET;
      else if ((w & branch_compare_pkg::MASK_BRANCH) == branch_compare_pkg::VAL_BR_CLEAR)
         classify = branch_compare_pkg::OP_BR_CLEAR;
      else
         classify = branch_compare_pkg::OP_NONE;
   endfunction : classify

   // Signed relative target, wrapping within program space
   function automatic logic [branch_compare_pkg::PC_W-1:0] relTarget(
      input logic [branch_compare_pkg::PC_W-1:0] base, input logic [11:0] offs);
      relTarget = branch_compare_pkg::PC_W'(base + offs[branch_compare_pkg::PC_W-1:0] + 1'b1);
   endfunction : relTarget

   // True when the skipped word opens a two-word instruction
   function automatic logic isLong(input logic [15:0] w);
      isLong = ((w & branch_compare_pkg::MASK_LONG_MEM) == branch_compare_pkg::VAL_LONG_MEM) ||
               ((w & branch_compare_pkg::MASK_LONG_FLOW) == branch_compare_pkg::VAL_LONG_FLOW);
   endfunction : isLong

   // Z N V and derived S after a result with a given overflow
   function automatic logic [7:0] resultFlags(input logic [7:0] f, input logic [7:0] res, input logic ovf);
      resultFlags = f;
      resultFlags[branch_compare_pkg::FLAG_Z] = (res == 8'h00);
      resultFlags[branch_compare_pkg::FLAG_N] = res[7];
      resultFlags[branch_compare_pkg::FLAG_V] = ovf;
      resultFlags[branch_compare_pkg::FLAG_S] = res[7] ^ ovf;
   endfunction : resultFlags

   branch_compare_pkg::exec_state_t state_r;
   branch_compare_pkg::op_t opKind;
   logic take;
   logic [1:0] waitCnt_r;
   logic [branch_compare_pkg::PC_W-1:0] pc_nxt;
   logic [7:0] status_flags_register_nxt;
   logic [7:0] regData_nxt;
   logic [4:0] regAddr_nxt;
   logic regWe_nxt;
   logic push_nxt;
   logic unknown_nxt;
   logic [1:0] cyc_nxt;
   logic [7:0] subB;
   logic subCin;
   logic [8:0] diff;
   logic halfBorrow;
   logic subOvf;
   logic skipCond;
   logic brCond;
   logic [branch_compare_pkg::PC_W-1:0] skipPc;
   logic [1:0] skipCyc;

   // New instructions are only taken while no multi-cycle one is running
   assign take = instrValid && ready;

   // Shared subtractor for the register, carry and immediate compares
   always_comb begin
      subB = (opKind == branch_compare_pkg::OP_CMP_IMM) ? {instrWord[11:8], instrWord[3:0]} : opR;
      subCin = (opKind == branch_compare_pkg::OP_CMP_CARRY) ? status_flags_register[branch_compare_pkg::FLAG_C] : 1'b0;
      diff = {1'b0, opD} - {1'b0, subB} - {8'h00, subCin};
      halfBorrow = (~opD[3] & subB[3]) | (subB[3] & diff[3]) | (diff[3] & ~opD[3]);
      subOvf = (opD[7] & ~subB[7] & ~diff[7]) | (~opD[7] & subB[7] & diff[7]);
   end

   // Skip size follows the length of the instruction being passed over
   always_comb begin
      skipPc = isLong(nextWord) ? branch_compare_pkg::PC_W'(pc + 2'h3) : branch_compare_pkg::PC_W'(pc + 2'h2);
      skipCyc = isLong(nextWord) ? branch_compare_pkg::CYC_THREE : branch_compare_pkg::CYC_TWO;
      brCond = status_flags_register[instrWord[2:0]];
   end

   // Decode and next-state computation
   always_comb begin
      opKind = classify(instrWord);
      pc_nxt = branch_compare_pkg::PC_W'(pc + 1'b1);
      status_flags_register_nxt = status_flags_register;
      regData_nxt = regData;
      regAddr_nxt = instrWord[8:4];
      regWe_nxt = 1'b0;
      push_nxt = 1'b0;
      unknown_nxt = 1'b0;
      cyc_nxt = branch_compare_pkg::CYC_ONE;
      skipCond = 1'b0;
      unique case (opKind)
         branch_compare_pkg::OP_DECREMENT: begin
            regData_nxt = opD - 8'h01;
            regWe_nxt = 1'b1;
            status_flags_register_nxt = resultFlags(status_flags_register, opD - 8'h01, opD == branch_compare_pkg::SIGNED_MIN);
         end
         branch_compare_pkg::OP_TEST: begin
            regData_nxt = opD & opD;
            regWe_nxt = 1'b1;
            status_flags_register_nxt = resultFlags(status_flags_register, opD & opD, 1'b0);
         end
         branch_compare_pkg::OP_ZERO_REG: begin
            regData_nxt = opD ^ opD;
            regWe_nxt = 1'b1;
            status_flags_register_nxt = resultFlags(status_flags_register, opD ^ opD, 1'b0);
         end
         branch_compare_pkg::OP_FILL_ONES: begin
            // Only the upper sixteen registers are reachable here
            regAddr_nxt = {1'b1, instrWord[7:4]};
            regData_nxt = branch_compare_pkg::ALL_ONES;
            regWe_nxt = 1'b1;
         end
         branch_compare_pkg::OP_REL_JUMP: begin
            pc_nxt = relTarget(pc, instrWord[11:0]);
            cyc_nxt = branch_compare_pkg::CYC_TWO;
         end
         branch_compare_pkg::OP_REL_CALL: begin
            pc_nxt = relTarget(pc, instrWord[11:0]);
            push_nxt = 1'b1;
            cyc_nxt = branch_compare_pkg::CYC_THREE;
         end
         branch_compare_pkg::OP_IND_JUMP: begin
            pc_nxt = zPointer[branch_compare_pkg::PC_W-1:0];
            cyc_nxt = branch_compare_pkg::CYC_TWO;
         end
         branch_compare_pkg::OP_IND_CALL: begin
            pc_nxt = zPointer[branch_compare_pkg::PC_W-1:0];
            push_nxt = 1'b1;
            cyc_nxt = branch_compare_pkg::CYC_THREE;
         end
         branch_compare_pkg::OP_CMP_SKIP: skipCond = (opD == opR);
         branch_compare_pkg::OP_CMP_REGS, branch_compare_pkg::OP_CMP_IMM: begin
            status_flags_register_nxt = resultFlags(status_flags_register, diff[7:0], subOvf);
            status_flags_register_nxt[branch_compare_pkg::FLAG_C] = diff[8];
            status_flags_register_nxt[branch_compare_pkg::FLAG_H] = halfBorrow;
         end
         branch_compare_pkg::OP_CMP_CARRY: begin
            status_flags_register_nxt = resultFlags(status_flags_register, diff[7:0], subOvf);
            // Zero only survives a chain of zero bytes
            status_flags_register_nxt[branch_compare_pkg::FLAG_Z] = (diff[7:0] == 8'h00) && status_flags_register[branch_compare_pkg::FLAG_Z];
            status_flags_register_nxt[branch_compare_pkg::FLAG_C] = diff[8];
            status_flags_register_nxt[branch_compare_pkg::FLAG_H] = halfBorrow;
         end
         branch_compare_pkg::OP_SKIP_RB_CLEAR: skipCond = !opR[instrWord[2:0]];
         branch_compare_pkg::OP_SKIP_RB_SET: skipCond = opR[instrWord[2:0]];
         branch_compare_pkg::OP_SKIP_IO_CLEAR: skipCond = !ioData[instrWord[2:0]];
         branch_compare_pkg::OP_SKIP_IO_SET: skipCond = ioData[instrWord[2:0]];
         branch_compare_pkg::OP_BR_SET, branch_compare_pkg::OP_BR_CLEAR: begin
            if (brCond == (opKind == branch_compare_pkg::OP_BR_SET)) begin
               pc_nxt = relTarget(pc, {{5{instrWord[9]}}, instrWord[9:3]});
               cyc_nxt = branch_compare_pkg::CYC_TWO;
            end
         end
         branch_compare_pkg::OP_NONE: unknown_nxt = 1'b1;
         default: unknown_nxt = 1'b1;
      endcase
      if (skipCond) begin
         pc_nxt = skipPc;
         cyc_nxt = skipCyc;
      end
   end

   // Issue state and stall counter
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= branch_compare_pkg::ST_READY;
         waitCnt_r <= 2'h0;
         ready <= 1'b1;
      end else begin
         unique case (state_r)
            branch_compare_pkg::ST_READY: begin
               if (take && (cyc_nxt != branch_compare_pkg::CYC_ONE)) begin
                  state_r <= branch_compare_pkg::ST_STALL;
                  waitCnt_r <= cyc_nxt - 2'h1;
                  ready <= 1'b0;
               end
            end
            branch_compare_pkg::ST_STALL: begin
               waitCnt_r <= waitCnt_r - 2'h1;
               if (waitCnt_r == 2'h1) begin
                  state_r <= branch_compare_pkg::ST_READY;
                  ready <= 1'b1;
               end
            end
         endcase
      end
   end

   // Program counter and flags
   always_ff @(posedge clk) begin
      if (rst) begin
         pc <= branch_compare_pkg::PC_RESET;
         status_flags_register <= branch_compare_pkg::STATUS_FLAGS_REGISTER_RESET;
      end else if (take) begin
         pc <= pc_nxt;
         status_flags_register <= status_flags_register_nxt;
      end
   end

   // Register file write port, one-cycle strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regWe <= 1'b0;
         regAddr <= 5'h00;
         regData <= 8'h00;
      end else begin
         regWe <= take && regWe_nxt;
         if (take) begin
            regAddr <= regAddr_nxt;
            regData <= regData_nxt;
         end
      end
   end

   // Return address push for calls, and unknown-opcode pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         pushValid <= 1'b0;
         pushAddr <= branch_compare_pkg::PC_RESET;
         unknownOp <= 1'b0;
      end else begin
         pushValid <= take && push_nxt;
         unknownOp <= take && unknown_nxt;
         if (take && push_nxt)
            pushAddr <= branch_compare_pkg::PC_W'(pc + 1'b1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Decrement keeps carry and writes Rd-1
   dec_flags_a: assert property ((take && opKind == branch_compare_pkg::OP_DECREMENT) |=>
      regWe && regData == $past(opD) - 8'h01 && status_flags_register[0] == $past(status_flags_register[0]))
      else $error("decrement result or carry wrong");

   // Test writes operand back with V cleared
   tst_result_a: assert property ((take && opKind == branch_compare_pkg::OP_TEST) |=>
      regWe && regData == $past(opD) && !status_flags_register[3] && status_flags_register[1] == ($past(opD) == 8'h00))
      else $error("test result or flags wrong");

   // Clear gives zero with Z set
   clr_zero_a: assert property ((take && opKind == branch_compare_pkg::OP_ZERO_REG) |=>
      regWe && regData == 8'h00 && status_flags_register[1] && !status_flags_register[2])
      else $error("clear result wrong");

   // Fill leaves flags alone
   fill_flags_a: assert property ((take && opKind == branch_compare_pkg::OP_FILL_ONES) |=>
      regData == 8'hFF && status_flags_register == $past(status_flags_register) && regAddr[4])
      else $error("fill changed flags or data");

   sequence stallOne_s;
      !ready ##1 ready;
   endsequence
   sequence stallTwo_s;
      !ready [*2] ##1 ready;
   endsequence

   // Relative jump: target and one-cycle stall
   relative_jump_time_a: assert property ((take && opKind == branch_compare_pkg::OP_REL_JUMP) |=>
      (pc == $past(pc) + $past(instrWord[10:0]) + 11'h001) and stallOne_s)
      else $error("relative jump target or timing wrong");

   // Calls stall for two cycles and push the return address
   call_time_a: assert property ((take && (opKind == branch_compare_pkg::OP_REL_CALL ||
      opKind == branch_compare_pkg::OP_IND_CALL)) |=> (pushValid && pushAddr == $past(pc) + 11'h001) ##0 stallTwo_s)
      else $error("call timing or push wrong");

   // Indirect jump loads Z pointer and keeps flags
   indirect_jump_target_a: assert property ((take && opKind == branch_compare_pkg::OP_IND_JUMP) |=>
      pc == $past(zPointer[10:0]) && status_flags_register == $past(status_flags_register) ##0 stallOne_s)
      else $error("indirect jump wrong");

   // Compares never store
   cmp_nostore_a: assert property ((take && (opKind == branch_compare_pkg::OP_CMP_REGS ||
      opKind == branch_compare_pkg::OP_CMP_CARRY || opKind == branch_compare_pkg::OP_CMP_IMM)) |=>
      !regWe && status_flags_register[0] == $past(diff[8]))
      else $error("compare stored or carry wrong");

   // Skips keep flags and never take one cycle when skipping
   skip_flags_a: assert property ((take && skipCond) |=>
      status_flags_register == $past(status_flags_register) && !ready && (pc == $past(pc) + 11'h002 || pc == $past(pc) + 11'h003))
      else $error("skip flags or timing wrong");

   // Untaken branch is one cycle and falls through
   br_untaken_a: assert property ((take && (opKind == branch_compare_pkg::OP_BR_SET ||
      opKind == branch_compare_pkg::OP_BR_CLEAR) && brCond != (opKind == branch_compare_pkg::OP_BR_SET)) |=>
      ready && pc == $past(pc) + 11'h001)
      else $error("untaken branch wrong");

endmodule : branch_compare_exec_unit

`default_nettype wire

//--- dv/prog_mem_model.sv
// Program memory model feeding instruction words to the execution unit.
// Assumes the bench loads words by hierarchical write before each issue.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   // Fetch address and words
   input wire logic [branch_compare_pkg::PC_W-1:0] pc,
   output logic [15:0] word,
   output logic [15:0] nextW
);
   logic [15:0] mem [0:(1 << branch_compare_pkg::PC_W)-1];
   // Words are seen without delay, as a flash read at fetch
   assign word = mem[pc];
   assign nextW = mem[pc + 11'h001];
endmodule : prog_mem_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the compare, skip and branch execution unit.
// Assumes one 20 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic instrValid = 1'b0;
   logic [7:0] opD = 8'h00, opR = 8'h00, ioData = 8'h00;
   logic [15:0] zPointer = 16'h0000, instrWord, nextWord;
   logic ready, unknownOp, regWe, pushValid;
   logic [branch_compare_pkg::PC_W-1:0] pc, pushAddr, expPc;
   logic [7:0] status_flags_register, regData;
   logic [4:0] regAddr;
   int failures = 0, comparisons = 0;
   logic tkn;
   always #25 clk = ~clk;
   prog_mem_model memU (.pc(pc), .word(instrWord), .nextW(nextWord));
   branch_compare_exec_unit dut_u (.clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
      .nextWord(nextWord), .opD(opD), .opR(opR), .ioData(ioData), .zPointer(zPointer), .ready(ready),
      .pc(pc), .status_flags_register(status_flags_register), .unknownOp(unknownOp), .regWe(regWe), .regAddr(regAddr), .regData(regData),
      .pushValid(pushValid), .pushAddr(pushAddr));
   // Compare seen against expected, four-state exact
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Issue one word, then check target and stall length
   task run(input logic [15:0] w, nw, input logic [7:0] d, r, input logic [15:0] z,
         input logic [10:0] np, input int cyc);
      memU.mem[expPc] = w;
      memU.mem[expPc + 11'h001] = nw;
      opD <= d;
      opR <= r;
      ioData <= r;
      zPointer <= z;
      instrValid <= 1'b1;
      @(posedge clk);
      instrValid <= 1'b0;
      #1;
      check(pc, np);
      check(ready, cyc == 1);
      check(pushValid, ((w & branch_compare_pkg::MASK_REL) == branch_compare_pkg::VAL_REL_CALL) ||
         (w == branch_compare_pkg::VAL_IND_CALL));
      repeat (cyc - 1) @(posedge clk);
      #1;
      check(ready, 1'b1);
      expPc = np;
   endtask : run
   // Every status bit, set and clear forms; flags must stay put
   task branches(input logic [7:0] f, input logic [6:0] k);
      for (int s = 0; s < 8; s++) begin
         for (int c = 0; c < 2; c++) begin
            tkn = (f[s] == (c == 0));
            run({5'b11110, c[0], k, s[2:0]}, 16'h0000, 8'h00, 8'h00, 16'h0000,
               tkn ? expPc + 11'h001 + {{4{k[6]}}, k} : expPc + 11'h001, tkn ? 2 : 1);
            check(status_flags_register, f);
         end
      end
   endtask : branches
   // Counts, verdict and end of run
   task test_done;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   // Watchdog at 4000 cycles, far beyond the ninety or so cycles the tests need
   initial begin
      #200000;
      failures++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      expPc = 11'h000;
      check(status_flags_register, 8'h00);
      // Compare 1 - 2 borrows on both nibbles
      run(16'h1412, 16'h0000, 8'h01, 8'h02, 16'h0000, expPc + 11'h001, 1);
      check(status_flags_register, 8'h35);
      // Decrement of 80h overflows; C and H kept
      run(16'h950A, 16'h0000, 8'h80, 8'h00, 16'h0000, expPc + 11'h001, 1);
      check({regWe, regAddr, regData}, {1'b1, 5'h10, 8'h7F});
      check(status_flags_register, 8'h39);
      check(unknownOp, 1'b0);
      branches(8'h39, 7'h03);
      // Equal immediate compare leaves only Z
      run(16'h3005, 16'h0000, 8'h05, 8'h00, 16'h0000, expPc + 11'h001, 1);
      check(status_flags_register, 8'h02);
      branches(8'h02, 7'h7E);
      $display("flags and branches done");
      run(16'h2033, 16'h0000, 8'h80, 8'h80, 16'h0000, expPc + 11'h001, 1);
      check({regData, status_flags_register}, 16'h8014);
      run(16'h2433, 16'h0000, 8'h5A, 8'h5A, 16'h0000, expPc + 11'h001, 1);
      check({regData, status_flags_register}, 16'h0002);
      run(16'hEF0F, 16'h0000, 8'h12, 8'h00, 16'h0000, expPc + 11'h001, 1);
      check({regData, status_flags_register}, 16'hFF02);
      $display("register ops done");
      run(16'hCFFF, 16'h0000, 8'h00, 8'h00, 16'h0000, expPc, 2);
      run(16'hD005, 16'h0000, 8'h00, 8'h00, 16'h0000, expPc + 11'h006, 3);
      check(pushAddr, expPc - 11'h005);
      run(16'h9409, 16'h0000, 8'h00, 8'h00, 16'h0123, 11'h123, 2);
      run(16'h9509, 16'h0000, 8'h00, 8'h00, 16'hF045, 11'h045, 3);
      check(pushAddr, 11'h124);
      check(status_flags_register, 8'h02);
      // Equal compare skips one or two words; unequal falls through
      run(16'h1012, 16'h0000, 8'h33, 8'h33, 16'h0000, expPc + 11'h002, 2);
      run(16'h1012, 16'h940C, 8'h33, 8'h33, 16'h0000, expPc + 11'h003, 3);
      run(16'h1012, 16'h0000, 8'h33, 8'h34, 16'h0000, expPc + 11'h001, 1);
      check(status_flags_register, 8'h02);
      // Bit skips on register and I/O, bit 3 both ways
      for (int v = 0; v < 2; v++) begin
         for (int i = 0; i < 4; i++) begin
            tkn = ((v == 0) == i[0]);
            run({i[1] ? 8'h99 : 8'hFC, 8'h03} | {6'h00, i[0], 9'h000}, 16'h0000, 8'h00,
               v == 0 ? 8'h08 : 8'hF7, 16'h0000, expPc + (tkn ? 11'h002 : 11'h001), tkn ? 2 : 1);
         end
      end
      check(status_flags_register, 8'h02);
      // A word outside this unit's classes steps the counter and pulses unknownOp
      run(16'h0000, 16'h0000, 8'h00, 8'h00, 16'h0000, expPc + 11'h001, 1);
      check({unknownOp, regWe, pushValid}, 3'b100);
      $display("jumps and skips done");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
